// file: src/idc_top.sv
//==============================================================
// Purpose : Control logic of an isolated digital I/O card
// Assumes : Classic Wishbone slave, one 250 MHz clock
// Notes   : Field pins pass a three-stage synchroniser
//==============================================================
`timescale 1ns/10ps
// Operation
// - Card identifier readable, switch on reads 0, top position is MSB.
// - Each input can interrupt, rising and falling edges enabled separately.
// - All interrupt sources merge onto one interrupt request line.
// - State, rising enable, falling enable and port identify registers govern interrupts.
// - Filter passes pulses of one interval, blocks half interval or less.
// - Filtering enabled per channel; all share one programmable interval.
// - Inputs are sampled on every 100 ns sample clock edge.
// - A counter makes the filter clock at half the filter interval.
// - New filtered level needs two consecutive filter clock edges agreeing.
// - Filter clock divisor is upper 16 bits of the preset register.
// - Rise and fall filtered alike; passing takes up to one interval.
// - On timeout outputs take safe pattern until disabled and rewritten.
// - After expiry all output writes are dropped until watchdog disabled.
// - Watchdog timeout is a 32-bit count of 100 ns ticks.
// - At power-up outputs take the pattern held in the EEPROM.
// - Software stores the power-up pattern through the EEPROM control register.
// - Hardware reset forces every output off.
// - Hot reset keeps outputs or loads defaults, chosen by jumper.
module idc_top (
  input  wire logic                       clk_i,                     // System clock
  input  wire logic                       rst_i,                     // Synchronous reset, high
  input  wire idc_pkg::idc_wb_req_t       wb_req_i,                  // Wishbone request group
  output logic                            wb_ack_o,                  // Wishbone acknowledge
  output logic [31:0]                     wb_dat_o,                  // Wishbone read data
  input  wire logic [idc_pkg::ID_W-1:0]   id_select_switch_i,        // DIP positions, high = on
  input  wire logic                       hot_reset_select_jumper_i, // High keeps outputs
  input  wire logic                       hot_reset_i,               // Hot reset request pin
  input  wire logic [idc_pkg::CH_W-1:0]   din_i,                     // Isolated input pins
  output logic      [idc_pkg::CH_W-1:0]   dout_o,                    // Output pins, high = sink
  output logic                            irq_o,                     // Host interrupt request
  input  wire logic [idc_pkg::CH_W-1:0]   ee_pattern_i,              // Stored power-up pattern
  output logic                            ee_store_o,                // Store strobe to EEPROM
  output logic      [idc_pkg::CH_W-1:0]   ee_data_o                  // Pattern to store
);
  idc_pkg::idc_state_t               st;
  idc_pkg::idc_state_t               next_st;
  logic                              stick;
  logic                              ftick;
  logic [15:0]                       fdiv_top;
  logic [idc_pkg::CH_W-1:0]          filt;
  logic [idc_pkg::CH_W-1:0]          chan;
  logic [idc_pkg::CH_W-1:0]          edge_ev;
  logic [idc_pkg::ID_W-1:0]          id_q;
  logic                              jump_q;
  logic                              hot_q;
  logic                              wb_req;
  logic                              wb_wr;
  logic [7:0]                        wb_ofs;
  logic [idc_pkg::PORT_W-1:0]        port_id;

  // ============================================================
  // Byte lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ============================================================
  // Qualified pins and derived ticks
  assign id_q     = st.q[idc_pkg::CH_W +: idc_pkg::ID_W];
  assign jump_q   = st.q[idc_pkg::PIN_W-2];
  assign hot_q    = st.q[idc_pkg::PIN_W-1];
  assign stick    = (st.sdiv == 5'h00);
  assign fdiv_top = (st.filt_pre[idc_pkg::FDIV_LSB +: 16] == 16'h0000) ? 16'h0000
                  : st.filt_pre[idc_pkg::FDIV_LSB +: 16] - 16'h0001;
  assign ftick    = stick && (st.fdiv == 16'h0000);

  // Filtered or sampled value per channel, then enabled edges
  assign chan     = (st.filt_en & filt) | (~st.filt_en & st.smp);
  assign edge_ev  = (chan & ~st.chan_prev & st.rise_en)
                  | (~chan & st.chan_prev & st.fall_en);

  // Port identify: one bit per group of eight pending channels
  always_comb begin
    for (int p = 0; p < idc_pkg::PORT_W; p++) begin
      port_id[p] = |st.int_state[8*p +: 8];
    end
  end

  // Bus decode
  assign wb_req = wb_req_i.cyc && wb_req_i.stb;
  assign wb_wr  = wb_req && wb_req_i.we && st.ack;
  assign wb_ofs = {wb_req_i.adr[7:2], 2'b00};

  // ============================================================
  // Filter of all input channels
  idc_filter #(
    .N      (idc_pkg::CH_W)
  ) u_filter (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (ftick),
    .smp_i  (st.smp),
    .filt_o (filt)
  );

  // ============================================================
  // Next state
  always_comb begin
    next_st          = st;
    next_st.ee_store = 1'b0;

    // Pin synchroniser, change taken once stages two and three agree
    next_st.s1 = {hot_reset_i, hot_reset_select_jumper_i, id_select_switch_i, din_i};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.q  = (st.s2 & st.s3) | (st.q & (st.s2 | st.s3));
    next_st.hot_prev = hot_q;

    // Sample clock divider and input sampling
    next_st.sdiv = stick ? idc_pkg::SDIV_TOP : st.sdiv - 5'h01;
    if (stick) begin
      next_st.smp  = st.q[idc_pkg::CH_W-1:0];
      next_st.fdiv = (st.fdiv == 16'h0000) ? fdiv_top : st.fdiv - 16'h0001;
    end

    // Sticky interrupt bits, a new edge wins over a clear
    next_st.chan_prev = chan;
    next_st.int_state = st.int_state | edge_ev;

    // Watchdog countdown in 100 ns ticks
    if (stick && st.wdg_en && !st.wdg_exp) begin
      if (st.wdg_cnt == 32'h0000_0000) begin
        next_st.wdg_exp = 1'b1;
      end else begin
        next_st.wdg_cnt = st.wdg_cnt - 32'h0000_0001;
      end
    end

    // Power-up load of the stored pattern
    if (st.boot) begin
      next_st.boot = 1'b0;
      next_st.dout = ee_pattern_i;
    end

    // Hot reset: jumper high keeps outputs, low reloads defaults
    if (hot_q && !st.hot_prev && !jump_q) begin
      next_st.dout    = ee_pattern_i;
      next_st.wdg_en  = 1'b0;
      next_st.wdg_exp = 1'b0;
    end

    // Bus: latch read data on the request, commit writes on the ack edge
    next_st.ack = wb_req && !st.ack;
    if (wb_req && !st.ack) begin
      unique case (wb_ofs)
        idc_pkg::OFS_CARD_ID   : next_st.rdat = {28'h0000000, ~id_q};
        idc_pkg::OFS_INT_STATE : next_st.rdat = st.int_state;
        idc_pkg::OFS_RISE_EN   : next_st.rdat = st.rise_en;
        idc_pkg::OFS_FALL_EN   : next_st.rdat = st.fall_en;
        idc_pkg::OFS_PORT_ID   : next_st.rdat = {28'h0000000, port_id};
        idc_pkg::OFS_FILT_EN   : next_st.rdat = st.filt_en;
        idc_pkg::OFS_FILT_PRE  : next_st.rdat = st.filt_pre;
        idc_pkg::OFS_WDG_CTRL  : next_st.rdat = {30'h0, st.wdg_exp, st.wdg_en};
        idc_pkg::OFS_WDG_TMO   : next_st.rdat = st.wdg_tmo;
        idc_pkg::OFS_WDG_SAFE  : next_st.rdat = st.safe;
        idc_pkg::OFS_DOUT      : next_st.rdat = st.pout;
        idc_pkg::OFS_EE_CTRL   : next_st.rdat = ee_pattern_i;
        default                : next_st.rdat = idc_pkg::RST_WORD;
      endcase
    end
    if (wb_wr) begin
      unique case (wb_ofs)
        idc_pkg::OFS_INT_STATE : next_st.int_state = (st.int_state & ~(merge(32'h0, wb_req_i.dat,
                                   wb_req_i.sel))) | edge_ev;
        idc_pkg::OFS_RISE_EN   : next_st.rise_en = merge(st.rise_en, wb_req_i.dat, wb_req_i.sel);
        idc_pkg::OFS_FALL_EN   : next_st.fall_en = merge(st.fall_en, wb_req_i.dat, wb_req_i.sel);
        idc_pkg::OFS_FILT_EN   : next_st.filt_en = merge(st.filt_en, wb_req_i.dat, wb_req_i.sel);
        idc_pkg::OFS_FILT_PRE  : next_st.filt_pre = merge(st.filt_pre, wb_req_i.dat, wb_req_i.sel);
        idc_pkg::OFS_WDG_CTRL  : begin
          if (wb_req_i.sel[0]) begin
            next_st.wdg_en = wb_req_i.dat[idc_pkg::WDG_EN_BIT];
            if (wb_req_i.dat[idc_pkg::WDG_EN_BIT] && !st.wdg_en) begin
              next_st.wdg_cnt = st.wdg_tmo;
            end
          end
        end
        idc_pkg::OFS_WDG_CLR   : begin
          if (st.wdg_en && !st.wdg_exp) begin
            next_st.wdg_cnt = st.wdg_tmo;
          end
        end
        idc_pkg::OFS_WDG_TMO   : next_st.wdg_tmo = merge(st.wdg_tmo, wb_req_i.dat, wb_req_i.sel);
        idc_pkg::OFS_WDG_SAFE  : next_st.safe = merge(st.safe, wb_req_i.dat, wb_req_i.sel);
        idc_pkg::OFS_DOUT      : begin
          if (!(st.wdg_en && st.wdg_exp)) begin
            next_st.dout = merge(st.dout, wb_req_i.dat, wb_req_i.sel);
            // Expiry clears only once disabled, so a same-cycle expiry wins
            if (!st.wdg_en) begin
              next_st.wdg_exp = 1'b0;
            end
          end
        end
        idc_pkg::OFS_EE_CTRL   : begin
          next_st.ee_data  = merge(st.ee_data, wb_req_i.dat, wb_req_i.sel);
          next_st.ee_store = 1'b1;
        end
        default                : ;
      endcase
    end

    // Driven pattern: safe pattern while expired
    next_st.pout = next_st.wdg_exp ? st.safe : next_st.dout;
  end

  // Register the state; reset drives every output off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st          <= '0;
      st.sdiv     <= idc_pkg::SDIV_TOP;
      st.filt_pre <= idc_pkg::RST_FILT_PRE;
      st.boot     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ============================================================
  // Outputs
  assign wb_ack_o   = st.ack;
  assign wb_dat_o   = st.rdat;
  assign dout_o     = st.pout;
  assign irq_o      = |st.int_state;
  assign ee_store_o = st.ee_store;
  assign ee_data_o  = st.ee_data;

  // ============================================================
  // Checks
  // Identifier read shows inverted switches
  id_read_a : assert property (@(posedge clk_i) disable iff (rst_i)
    st.ack && wb_req && !wb_req_i.we && (wb_ofs == idc_pkg::OFS_CARD_ID)
      |-> wb_dat_o[3:0] == ~$past(id_q))
    else $error("card identifier read wrong");

  // Enabled edge sets its state bit
  edge_irq_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (edge_ev != '0) |=> irq_o && ((st.int_state & $past(edge_ev)) == $past(edge_ev)))
    else $error("enabled edge did not raise interrupt");

  // Pending source shows on line and port bit
  irq_merge_a : assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st.int_state[0]) |-> irq_o ##0 port_id[0])
    else $error("pending source not seen on interrupt line");

  // Sample enable followed by at least eight idle cycles
  sample_tick_a : assert property (@(posedge clk_i) disable iff (rst_i)
    stick |=> !stick [*8])
    else $error("sample tick too frequent");

  // Divided filter enable followed by at least eight idle cycles
  ftick_gap_a : assert property (@(posedge clk_i) disable iff (rst_i)
    ftick && (fdiv_top != 16'h0000) |=> !ftick [*8])
    else $error("filter tick faster than programmed");

  // Expired watchdog drives the safe pattern
  wdg_safe_a : assert property (@(posedge clk_i) disable iff (rst_i)
    st.wdg_exp && $stable(st.safe) && $past(st.wdg_exp) |-> dout_o == st.safe)
    else $error("expired watchdog not showing safe pattern");

  // Output writes dropped after expiry
  wdg_ignore_a : assert property (@(posedge clk_i) disable iff (rst_i)
    wb_wr && (wb_ofs == idc_pkg::OFS_DOUT) && st.wdg_en && st.wdg_exp |=> $stable(st.dout))
    else $error("output write taken after expiry");

  // Reset leaves every output off
  reset_off_a : assert property (@(posedge clk_i)
    rst_i |=> dout_o == '0)
    else $error("outputs not off after reset");

  // Store write gives a one-cycle strobe
  ee_store_a : assert property (@(posedge clk_i) disable iff (rst_i)
    wb_wr && (wb_ofs == idc_pkg::OFS_EE_CTRL) |=> ee_store_o ##1 !ee_store_o)
    else $error("store strobe missing");

  // Acknowledge lasts one cycle only
  ack_once_a : assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held too long");

  // Port identify read shows pending groups
  port_read_a : assert property (@(posedge clk_i) disable iff (rst_i)
    st.ack && wb_req && !wb_req_i.we && (wb_ofs == idc_pkg::OFS_PORT_ID)
      |-> wb_dat_o[3:0] == $past(port_id))
    else $error("port identify read wrong");

  // Only an enabled channel sets its bit
  irq_source_a : assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st.int_state[0]) |-> $past(st.rise_en[0] || st.fall_en[0]))
    else $error("state bit set without an enable");

  // Samples move only on the sample enable
  smp_tick_a : assert property (@(posedge clk_i) disable iff (rst_i)
    !$stable(st.smp) |-> $past(stick))
    else $error("inputs sampled off the sample enable");

  // Running watchdog counts one per tick
  wdg_count_a : assert property (@(posedge clk_i) disable iff (rst_i)
    stick && st.wdg_en && !st.wdg_exp && (st.wdg_cnt != 32'h0000_0000) && !wb_wr
      |=> st.wdg_cnt == $past(st.wdg_cnt) - 32'h0000_0001)
    else $error("watchdog count step wrong");

  // Exhausted count on a tick sets expiry
  wdg_expire_a : assert property (@(posedge clk_i) disable iff (rst_i)
    stick && st.wdg_en && !st.wdg_exp && (st.wdg_cnt == 32'h0000_0000)
      && !(hot_q && !st.hot_prev && !jump_q) |=> st.wdg_exp)
    else $error("watchdog did not expire");

  // Clear command reloads the timeout
  wdg_reload_a : assert property (@(posedge clk_i) disable iff (rst_i)
    wb_wr && (wb_ofs == idc_pkg::OFS_WDG_CLR) && st.wdg_en && !st.wdg_exp
      |=> st.wdg_cnt == $past(st.wdg_tmo))
    else $error("clear did not reload watchdog");

  // First cycle out of reset loads the pattern
  boot_load_a : assert property (@(posedge clk_i) disable iff (rst_i)
    st.boot |=> dout_o == $past(ee_pattern_i))
    else $error("power-up pattern not loaded");

  // Hot reset with jumper high keeps outputs
  hot_keep_a : assert property (@(posedge clk_i) disable iff (rst_i)
    hot_q && !st.hot_prev && jump_q && !wb_wr && !st.boot |=> $stable(st.dout))
    else $error("hot reset changed kept outputs");

  // Hot reset with jumper low reloads, disarms
  hot_load_a : assert property (@(posedge clk_i) disable iff (rst_i)
    hot_q && !st.hot_prev && !jump_q && !wb_wr
      |=> (st.dout == $past(ee_pattern_i)) && !st.wdg_en)
    else $error("hot reset did not reload pattern");

  // Store write hands the word to the EEPROM
  ee_data_a : assert property (@(posedge clk_i) disable iff (rst_i)
    wb_wr && (wb_ofs == idc_pkg::OFS_EE_CTRL) && (wb_req_i.sel == 4'hF)
      |=> ee_data_o == $past(wb_req_i.dat))
    else $error("store data wrong");
endmodule

// file: src/idc_pkg.sv
//==============================================================
// Purpose : Shared constants and types of the isolated DIO control logic
// Assumes : 250 MHz system clock, 32 input and 32 output channels
// Notes   : Offsets are Wishbone byte addresses of 32-bit words
//==============================================================
package idc_pkg;
  // ============================================================
  // Timing
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          SAMPLE_NS     = 100;
  localparam int          SAMPLE_CYC    = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0]  SDIV_TOP      = 5'(SAMPLE_CYC - 1);
  // ============================================================
  // Widths
  localparam int          CH_W          = 32;
  localparam int          PORT_W        = CH_W / 8;
  localparam int          ID_W          = 4;
  localparam int          PIN_W         = CH_W + ID_W + 2;
  localparam int          FDIV_LSB      = 16;
  // ============================================================
  // Register offsets
  localparam logic [7:0]  OFS_CARD_ID   = 8'h00;
  localparam logic [7:0]  OFS_INT_STATE = 8'h04;
  localparam logic [7:0]  OFS_RISE_EN   = 8'h08;
  localparam logic [7:0]  OFS_FALL_EN   = 8'h0C;
  localparam logic [7:0]  OFS_PORT_ID   = 8'h10;
  localparam logic [7:0]  OFS_FILT_EN   = 8'h14;
  localparam logic [7:0]  OFS_FILT_PRE  = 8'h18;
  localparam logic [7:0]  OFS_WDG_CTRL  = 8'h1C;
  localparam logic [7:0]  OFS_WDG_CLR   = 8'h20;
  localparam logic [7:0]  OFS_WDG_TMO   = 8'h24;
  localparam logic [7:0]  OFS_WDG_SAFE  = 8'h28;
  localparam logic [7:0]  OFS_DOUT      = 8'h2C;
  localparam logic [7:0]  OFS_EE_CTRL   = 8'h30;
  // ============================================================
  // Fields and reset values
  localparam int          WDG_EN_BIT    = 0;
  localparam int          WDG_EXP_BIT   = 1;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [31:0] RST_FILT_PRE  = 32'h0001_0000;
  // ============================================================
  // Types
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } idc_wb_req_t;

  typedef struct packed {
    logic [CH_W-1:0] prev;
    logic [CH_W-1:0] out;
  } idc_filt_t;

  typedef struct packed {
    logic [4:0]       sdiv;
    logic [15:0]      fdiv;
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] q;
    logic             hot_prev;
    logic [CH_W-1:0]  smp;
    logic [CH_W-1:0]  chan_prev;
    logic [CH_W-1:0]  int_state;
    logic [CH_W-1:0]  rise_en;
    logic [CH_W-1:0]  fall_en;
    logic [CH_W-1:0]  filt_en;
    logic [31:0]      filt_pre;
    logic             wdg_en;
    logic             wdg_exp;
    logic [31:0]      wdg_cnt;
    logic [31:0]      wdg_tmo;
    logic [CH_W-1:0]  safe;
    logic [CH_W-1:0]  dout;
    logic [CH_W-1:0]  pout;
    logic             boot;
    logic             ee_store;
    logic [CH_W-1:0]  ee_data;
    logic             ack;
    logic [31:0]      rdat;
  } idc_state_t;
endpackage

// file: src/idc_filter.sv
//==============================================================
// Purpose : Two-edge glitch filter for all input channels
// Assumes : tick_i is the one-cycle filter clock enable
// Notes   : A level is taken once seen at two successive ticks
//==============================================================
`timescale 1ns/10ps
module idc_filter #(
  parameter int N = idc_pkg::CH_W
) (
  input  wire logic         clk_i,  // System clock
  input  wire logic         rst_i,  // Synchronous reset, high
  input  wire logic         tick_i, // Filter clock enable
  input  wire logic [N-1:0] smp_i,  // Sampled inputs
  output logic      [N-1:0] filt_o  // Filtered inputs
);
  idc_pkg::idc_filt_t st;
  idc_pkg::idc_filt_t next_st;

  // ============================================================
  // Next state: adopt only levels stable over two filter edges
  always_comb begin
    next_st = st;
    if (tick_i) begin
      next_st.prev = smp_i;
      next_st.out  = (smp_i & ~(smp_i ^ st.prev)) | (st.out & (smp_i ^ st.prev));
    end
  end

  // Register the state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign filt_o = st.out;

  // ============================================================
  // Checks
  filt_on_tick_a : assert property (@(posedge clk_i) disable iff (rst_i)
    !$stable(filt_o) |-> $past(tick_i))
    else $error("filtered level moved without a filter tick");
  filt_agree_a : assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(filt_o[0]) |-> $past(smp_i[0]) && $past(st.prev[0]))
    else $error("filtered rise without two equal samples");
endmodule

// file: sim/idc_eeprom_model.sv
//==============================================================
// Purpose : Behavioural EEPROM holding the power-up output pattern
// Assumes : Store strobe is a one-cycle pulse in the system clock domain
// Notes   : Blank part reads all zeros until the first store
//==============================================================
`timescale 1ns/10ps
module idc_eeprom_model (
  input  wire logic                     clk_i,     // System clock
  input  wire logic                     store_i,   // Store strobe
  input  wire logic [idc_pkg::CH_W-1:0] data_i,    // Pattern to store
  output logic      [idc_pkg::CH_W-1:0] pattern_o  // Stored pattern
);
  // ============================================================
  // Storage, factory content all zeros
  initial begin
    pattern_o = '0;
    forever begin
      @(posedge clk_i);
      if (store_i === 1'b1) begin
        pattern_o <= data_i;
      end
    end
  end
endmodule

// file: sim/idc_top_tb.sv
//==============================================================
// Purpose : Self-checking bench of the isolated DIO control logic
// Assumes : Classic Wishbone master, 250 MHz clock, pins synchronised
// Notes   : Filter divisor 2 gives a 400 ns interval
//==============================================================
`timescale 1ns/10ps
module idc_top_tb;
  logic                  clk_i, rst_i, jmp, hot, ee_store, irq, ack;
  idc_pkg::idc_wb_req_t  req;
  logic [31:0]           rdat, dout, din, ee_pat, ee_dat, rd;
  logic [3:0]            sw;
  int                    failures, comparisons, cycles;

  // ============================================================
  // Clock, timeout and instances
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end
  idc_top i_idc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(rdat),
    .id_select_switch_i(sw), .hot_reset_select_jumper_i(jmp), .hot_reset_i(hot), .din_i(din),
    .dout_o(dout), .irq_o(irq), .ee_pattern_i(ee_pat), .ee_store_o(ee_store), .ee_data_o(ee_dat));
  idc_eeprom_model i_idc_eeprom_model (.clk_i(clk_i), .store_i(ee_store), .data_i(ee_dat),
    .pattern_o(ee_pat));

  // ============================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One classic cycle; holds until ack is seen at a rising edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    req <= '0;
  endtask
  task automatic pin(input logic [31:0] d, input int n);
    @(posedge clk_i);
    din <= d;
    clks(n);
  endtask
  task automatic hot_pulse(input logic j);
    @(posedge clk_i);
    jmp <= j;
    hot <= 1'b1;
    clks(10);
    hot <= 1'b0;
    clks(10);
  endtask

  // ============================================================
  // Scenarios
  task automatic t_card_id;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      sw <= 4'(i);
      clks(6);
      wb(1'b0, idc_pkg::OFS_CARD_ID, 32'h0);
      check(rd, {28'h0, ~4'(i)}, "card id");
    end
    wb(1'b0, 8'h3C, 32'h0);
    check(rd, 32'h0000_0000, "unmapped read");
  endtask
  task automatic t_irq;
    wb(1'b1, idc_pkg::OFS_FALL_EN, 32'h0000_0200);
    wb(1'b1, idc_pkg::OFS_RISE_EN, 32'h0000_0003);
    pin(32'h0000_0201, 100);
    wb(1'b0, idc_pkg::OFS_INT_STATE, 32'h0);
    check(rd, 32'h0000_0001, "rising state");
    check({31'h0, irq}, 32'h1, "irq raised");
    wb(1'b0, idc_pkg::OFS_PORT_ID, 32'h0);
    check(rd, 32'h0000_0001, "port id 0");
    wb(1'b1, idc_pkg::OFS_INT_STATE, 32'h0000_0001);
    clks(2);
    check({31'h0, irq}, 32'h0, "irq cleared");
    pin(32'h0000_0000, 100);
    wb(1'b0, idc_pkg::OFS_INT_STATE, 32'h0);
    check(rd, 32'h0000_0200, "falling state");
    wb(1'b0, idc_pkg::OFS_PORT_ID, 32'h0);
    check(rd, 32'h0000_0002, "port id 1");
    wb(1'b1, idc_pkg::OFS_INT_STATE, 32'hFFFF_FFFF);
  endtask
  task automatic t_filter;
    wb(1'b1, idc_pkg::OFS_FILT_PRE, 32'h0002_0000);
    wb(1'b1, idc_pkg::OFS_FILT_EN, 32'h0000_0002);
    wb(1'b0, idc_pkg::OFS_FILT_PRE, 32'h0);
    check(rd, 32'h0002_0000, "preset readback");
    pin(32'h0000_0002, 30);
    pin(32'h0000_0000, 250);
    wb(1'b0, idc_pkg::OFS_INT_STATE, 32'h0);
    check(rd, 32'h0000_0000, "glitch blocked");
    pin(32'h0000_0002, 250);
    wb(1'b0, idc_pkg::OFS_INT_STATE, 32'h0);
    check(rd, 32'h0000_0002, "pulse passed");
    wb(1'b1, idc_pkg::OFS_FALL_EN, 32'h0000_0002);
    wb(1'b1, idc_pkg::OFS_INT_STATE, 32'hFFFF_FFFF);
    pin(32'h0000_0000, 250);
    wb(1'b0, idc_pkg::OFS_INT_STATE, 32'h0);
    check(rd, 32'h0000_0002, "fall passed");
  endtask
  task automatic t_watchdog;
    wb(1'b1, idc_pkg::OFS_WDG_TMO, 32'h0000_0003);
    wb(1'b1, idc_pkg::OFS_WDG_SAFE, 32'hA5A5_0F0F);
    wb(1'b1, idc_pkg::OFS_DOUT, 32'h1234_5678);
    wb(1'b1, idc_pkg::OFS_WDG_CTRL, 32'h0000_0001);
    repeat (4) begin
      clks(40);
      wb(1'b1, idc_pkg::OFS_WDG_CLR, 32'h0);
    end
    check(dout, 32'h1234_5678, "kept alive");
    clks(150);
    check(dout, 32'hA5A5_0F0F, "safe pattern");
    wb(1'b0, idc_pkg::OFS_WDG_CTRL, 32'h0);
    check(rd, 32'h0000_0003, "expired flag");
    wb(1'b1, idc_pkg::OFS_DOUT, 32'hFFFF_0000);
    clks(2);
    check(dout, 32'hA5A5_0F0F, "write dropped");
    wb(1'b1, idc_pkg::OFS_WDG_CTRL, 32'h0);
    wb(1'b1, idc_pkg::OFS_DOUT, 32'h0000_FFFF);
    clks(2);
    check(dout, 32'h0000_FFFF, "new outputs");
    wb(1'b0, idc_pkg::OFS_DOUT, 32'h0);
    check(rd, 32'h0000_FFFF, "output readback");
    wb(1'b0, idc_pkg::OFS_WDG_TMO, 32'h0);
    check(rd, 32'h0000_0003, "timeout readback");
  endtask
  task automatic t_power;
    hot_pulse(1'b1);
    check(dout, 32'h0000_FFFF, "hot keep");
    wb(1'b1, idc_pkg::OFS_EE_CTRL, 32'h5A5A_C3C3);
    clks(2);
    wb(1'b0, idc_pkg::OFS_EE_CTRL, 32'h0);
    check(rd, 32'h5A5A_C3C3, "stored pattern");
    hot_pulse(1'b0);
    check(dout, 32'h5A5A_C3C3, "hot reload");
    rst_i <= 1'b1;
    clks(3);
    rst_i <= 1'b0;
    clks(1);
    check(dout, 32'h0000_0000, "mid-run reset off");
    clks(1);
    check(dout, 32'h5A5A_C3C3, "stored power-up");
  endtask

  // ============================================================
  // Verdict and main sequence
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    req = '0;
    sw = 4'h0;
    jmp = 1'b1;
    hot = 1'b0;
    din = 32'h0000_0200;
    failures = 0;
    comparisons = 0;
    cycles = 0;
    clks(3);
    check(dout, 32'h0000_0000, "reset outputs off");
    rst_i <= 1'b0;
    clks(4);
    check(dout, 32'h0000_0000, "blank power-up");
    t_card_id();
    t_irq();
    t_filter();
    t_watchdog();
    t_power();
    results();
  end
endmodule
